// File: fault_supervisor.v
// flyback fault supervisor: gates the low-side drive, runs recovery
// assumes comparator and sense inputs are synchronous to clk_in
//
// Behaviour
// - output short at power limit starts 160 ms timer
// - supply-off with overpower or low sense: recover now
// - three over-current pulses stop switching, bias low
// - fault response cycles supply only, no pulses
// - restart at first supply-off after recovery
// - reference rail low stops switching, restart cycle
// - held reference low stays off, no switching
// - overtemperature forces restart, stays off while hot
// - pin faults auto-recover, never latch
// - short sense pin checked on first pulse only
// - select high: first pulse over 2 us faults
// - select low: limit 2 us or 1 us by resistor
// - sense pin high three pulses: start recovery
// - bias pin falls within 10 us: forced restart
// - bias pin overvoltage three pulses: forced restart
// - discharge pin overvoltage 750 us: forced restart
// - during recovery timer stay faulted, no switching
`timescale 1ns/100ps
`include "fault_sup_regs.vh"
module fault_supervisor #(
   parameter [25:0] OPP_CYC = `OPP_TIMER_CYC,
   parameter [25:0] RECOVERY_CYC = `RECOVERY_CYC,
   parameter OPP_TIMER_EN = 1,
   parameter CAP_OV_EN = 1
) (
   input wire clk_in,
   input wire rst_in,
   input wire gate_request_in,
   input wire supply_on_in,
   input wire supply_off_in,
   input wire over_power_in,
   input wire peak_power_limit_in,
   input wire voltage_sense_low_in,
   input wire over_current_in,
   input wire blanking_done_in,
   input wire demag_active_in,
   input wire ref_good_in,
   input wire over_temp_in,
   input wire select_in,
   input wire demag_res_high_in,
   input wire bias_below_14v_in,
   input wire bias_over_in,
   input wire timing_res_fault_in,
   input wire cap_discharge_ov_in,
   output wire low_side_gate_drive_out,
   output reg bias_enable_out,
   output reg force_restart_out,
   output reg recovery_active_out,
   output reg over_current_fault_out
);
   // ************************************************
   // state machine
   // ************************************************
   localparam [2:0] ST_OFF = 3'h0;
   localparam [2:0] ST_CHECK = 3'h1;
   localparam [2:0] ST_RUN = 3'h2;
   localparam [2:0] ST_RECOVER = 3'h3;
   localparam [2:0] ST_WAIT_OFF = 3'h4;
   localparam [2:0] ST_RESTART = 3'h5;
   localparam [7:0] FIRST_LONG_LAST = `PULSE_LONG_CYC - 1;
   localparam [7:0] FIRST_SHORT_LAST = `PULSE_SHORT_CYC - 1;
   localparam [25:0] BIAS_CHECK_CNT = `BIAS_CHECK_CYC;
   localparam [15:0] CAP_OV_CNT = `CAP_OV_CYC;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [25:0] timer_q;
   reg [25:0] opp_q;
   reg [15:0] cap_q;
   reg [7:0] on_q;
   reg first_q;
   reg gate_q;
   reg oc_seen_q;
   reg cs_seen_q;
   reg bias_seen_q;
   wire pulse_end;
   wire oc_trip;
   wire cs_open_trip;
   wire bias_trip;
   wire [7:0] first_limit;
   wire first_too_long;
   wire opp_done;
   wire cap_done;
   wire hard_fault;
   wire recover_fault;
   wire switching;
   wire oc_now;
   wire cs_now;
   wire bias_now;

   function [25:0] sat_inc;
      input [25:0] v;
      begin
         sat_inc = (v == 26'h3FFFFFF) ? v : v + 26'h1;
      end
   endfunction

   function [7:0] sat_inc8;
      input [7:0] v;
      begin
         sat_inc8 = (v == 8'hFF) ? v : v + 8'h1;
      end
   endfunction

   function [15:0] sat_inc16;
      input [15:0] v;
      begin
         sat_inc16 = (v == 16'hFFFF) ? v : v + 16'h1;
      end
   endfunction

   assign switching = (state_q == ST_RUN);
   // gate is registered: cut at the clock edge after a fault is seen
   assign low_side_gate_drive_out = gate_q;
   assign pulse_end = gate_q && !(gate_request_in && switching);

   // ************************************************
   // fault detectors
   // ************************************************
   // limit is the last allowed on cycle, so a cut
   // first pulse is exactly the limit wide and never a cycle more
   assign first_limit = (select_in || demag_res_high_in) ?
      FIRST_LONG_LAST : FIRST_SHORT_LAST;
   assign first_too_long = first_q && gate_q && (on_q >= first_limit);

   pulse_streak oc_streak (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(!switching),
      .pulse_end_in(pulse_end),
      .seen_in(oc_seen_q || oc_now),
      .trip_out(oc_trip)
   );
   pulse_streak cs_streak (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(!switching),
      .pulse_end_in(pulse_end),
      .seen_in(cs_seen_q || cs_now),
      .trip_out(cs_open_trip)
   );
   pulse_streak bias_streak (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(!switching),
      .pulse_end_in(pulse_end),
      .seen_in(bias_seen_q || bias_now),
      .trip_out(bias_trip)
   );

   assign opp_done = (OPP_TIMER_EN != 0) && (opp_q >= OPP_CYC);
   assign cap_done = (CAP_OV_EN != 0) &&
      (cap_q >= CAP_OV_CNT);
   // faults answered by one supply restart cycle only
   assign hard_fault = !ref_good_in || over_temp_in || bias_trip ||
      cap_done;
   assign recover_fault = oc_trip || cs_open_trip || first_too_long ||
      opp_done;
   // closing-cycle events still count for the pulse that ends
   // only between blanking and demag end counts
   assign oc_now = over_current_in && blanking_done_in &&
      (gate_q || demag_active_in);
   // open sense pin pulled high is seen off-pulse
   assign cs_now = over_current_in && !gate_q;
   assign bias_now = bias_over_in;

   // ************************************************
   // sequencing
   // ************************************************
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            // held reference low never leaves here
            if (supply_on_in && ref_good_in && !over_temp_in) begin
               state_d = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (timing_res_fault_in) begin
               state_d = ST_RESTART;
            end else if (timer_q >= BIAS_CHECK_CNT) begin
               // pin open only sags fast, so low here means open
               state_d = bias_below_14v_in ? ST_RESTART : ST_RUN;
            end
         end
         ST_RUN: begin
            if (supply_off_in && (over_power_in || voltage_sense_low_in)) begin
               state_d = ST_RECOVER;
            end else if (hard_fault || supply_off_in) begin
               state_d = ST_RESTART;
            end else if (recover_fault) begin
               state_d = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            if (timer_q >= RECOVERY_CYC) begin
               state_d = ST_WAIT_OFF;
            end
         end
         ST_WAIT_OFF: begin
            if (supply_off_in) begin
               state_d = ST_OFF;
            end
         end
         ST_RESTART: begin
            // supply collapse ends the cycle; repeats if still faulty
            if (supply_off_in) begin
               state_d = ST_OFF;
            end
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
   end

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= ST_OFF;
         timer_q <= 26'h0;
      end else begin
         state_q <= state_d;
         timer_q <= (state_d != state_q) ? 26'h0 : sat_inc(timer_q);
      end
   end

   // ************************************************
   // fault timers
   // ************************************************
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         opp_q <= 26'h0;
         cap_q <= 16'h0;
      end else begin
         // power limit hit continuously runs the long timer
         opp_q <= (switching && peak_power_limit_in) ? sat_inc(opp_q)
            : 26'h0;
         // any gap in the overvoltage restarts the count
         cap_q <= cap_discharge_ov_in ? sat_inc16(cap_q) : 16'h0;
      end
   end

   // ************************************************
   // gate and pulse tracking
   // ************************************************
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         gate_q <= 1'b0;
         on_q <= 8'h0;
         first_q <= 1'b1;
      end else begin
         // only the run state may pulse
         gate_q <= gate_request_in && (state_d == ST_RUN) &&
            !first_too_long;
         on_q <= gate_q ? sat_inc8(on_q) : 8'h0;
         if (state_q == ST_OFF) begin
            first_q <= 1'b1;
         end else if (pulse_end) begin
            first_q <= 1'b0;
         end
      end
   end

   // ************************************************
   // per-pulse fault flags
   // ************************************************
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         oc_seen_q <= 1'b0;
         cs_seen_q <= 1'b0;
         bias_seen_q <= 1'b0;
      end else if (pulse_end || !switching) begin
         oc_seen_q <= 1'b0;
         cs_seen_q <= 1'b0;
         bias_seen_q <= 1'b0;
      end else begin
         if (oc_now) begin
            oc_seen_q <= 1'b1;
         end
         if (cs_now) begin
            cs_seen_q <= 1'b1;
         end
         if (bias_now) begin
            bias_seen_q <= 1'b1;
         end
      end
   end

   // ************************************************
   // status outputs
   // ************************************************
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         bias_enable_out <= 1'b0;
         force_restart_out <= 1'b0;
         recovery_active_out <= 1'b0;
         over_current_fault_out <= 1'b0;
      end else begin
         bias_enable_out <= (state_d == ST_RUN) ||
            (state_d == ST_CHECK);
         force_restart_out <= (state_d == ST_RESTART);
         recovery_active_out <= (state_d == ST_RECOVER);
         // set wins over the clear in one cycle
         if (state_q == ST_RUN && oc_trip) begin
            over_current_fault_out <= 1'b1;
         end else if (state_d == ST_OFF) begin
            over_current_fault_out <= 1'b0;
         end
      end
   end
endmodule // fault_supervisor

// File: fault_sup_regs.vh
// fault supervisor constants: timing figures and derived cycle counts
// assumes a 40 MHz clock; included by both design files
`ifndef FAULT_SUP_REGS_VH
`define FAULT_SUP_REGS_VH
`define CLK_MHZ 40
`define OPP_TIMER_MS 160
`define OPP_TIMER_CYC (`OPP_TIMER_MS * 1000 * `CLK_MHZ)
`define RECOVERY_MS 1500
`define RECOVERY_CYC (`RECOVERY_MS * 1000 * `CLK_MHZ)
`define CAP_OV_US 750
`define CAP_OV_CYC (`CAP_OV_US * `CLK_MHZ)
`define BIAS_CHECK_US 10
`define BIAS_CHECK_CYC (`BIAS_CHECK_US * `CLK_MHZ)
`define PULSE_LONG_US 2
`define PULSE_LONG_CYC (`PULSE_LONG_US * `CLK_MHZ)
`define PULSE_SHORT_US 1
`define PULSE_SHORT_CYC (`PULSE_SHORT_US * `CLK_MHZ)
`define CONSEC_PULSES 3
`define CNT_W 26
`endif

// File: pulse_streak.v
// three-in-a-row counter of gate pulses showing a condition
// assumes pulse_end_in is a one-cycle strobe at each gate pulse end
`timescale 1ns/100ps
`include "fault_sup_regs.vh"
module pulse_streak (
   input wire clk_in,
   input wire rst_in,
   input wire clear_in,
   input wire pulse_end_in,
   input wire seen_in,
   output wire trip_out
);
   localparam [1:0] TRIP_AT = `CONSEC_PULSES - 1;
   reg [1:0] count_q;
   // a clean pulse breaks the streak
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         count_q <= 2'h0;
      end else if (clear_in) begin
         count_q <= 2'h0;
      end else if (pulse_end_in) begin
         if (!seen_in) begin
            count_q <= 2'h0;
         end else if (count_q != 2'h3) begin
            count_q <= count_q + 2'h1;
         end
      end
   end
   assign trip_out = pulse_end_in && seen_in &&
      (count_q == TRIP_AT);
endmodule // pulse_streak

// File: fault_supervisor_monitor.sv
// checker on the fault supervisor ports
// assumes it is bound onto every fault_supervisor
`timescale 1ns/100ps
module fault_supervisor_monitor (
   input wire clk_in,
   input wire rst_in,
   input wire gate_request_in,
   input wire ref_good_in,
   input wire over_temp_in,
   input wire low_side_gate_drive_out,
   input wire bias_enable_out,
   input wire force_restart_out,
   input wire recovery_active_out,
   input wire over_current_fault_out
);
   wire gate = low_side_gate_drive_out;
   wire rec = recovery_active_out;
   wire rsr = force_restart_out;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   sequence s_trip; $rose(over_current_fault_out); endsequence
   // two cycles: the gate is registered, one late edge is allowed
   sequence s_two(x); x ##1 x; endsequence
   chk_trip_bias_low: assert property (s_trip |-> !bias_enable_out)
      else $error("bias on at trip");
   chk_trip_recovers: assert property (s_trip |-> rec)
      else $error("no recovery at trip");
   chk_recover_no_gate: assert property (s_two(rec) |-> !gate)
      else $error("gate in recovery");
   chk_restart_no_gate: assert property (s_two(rsr) |-> !gate)
      else $error("gate in restart");
   chk_gate_needs_req: assert property (gate |-> $past(gate_request_in))
      else $error("gate without request");
   chk_ref_stop: assert property (s_two(!ref_good_in) |-> !gate)
      else $error("gate with ref low");
   chk_hot_stop: assert property (s_two(over_temp_in) |-> !gate)
      else $error("gate while hot");
   chk_recover_holds: assert property ($rose(rec) |-> rec[*8])
      else $error("recovery dropped early");
endmodule // fault_supervisor_monitor
bind fault_supervisor fault_supervisor_monitor fault_supervisor_monitor_i (
   .clk_in, .rst_in, .gate_request_in, .ref_good_in, .over_temp_in,
   .low_side_gate_drive_out, .bias_enable_out, .force_restart_out,
   .recovery_active_out, .over_current_fault_out);

// File: power_stage_model.sv
// power stage model: blanking, demag and sense comparator
// assumes gate_in is the low-side drive of the supervisor
`timescale 1ns/100ps
module power_stage_model (
   input wire clk_in,
   input wire gate_in,
   input wire sense_hi_in,
   input wire open_in,
   output wire blank_done_out,
   output wire demag_out,
   output wire sense_trip_out
);
   reg [1:0] on_q = 2'h0;
   assign blank_done_out = on_q == 2'h3;
   // crude: demag taken as the whole off time
   assign demag_out = ~gate_in;
   // open pin floats to its pull-up, over the trip level at all times
   assign sense_trip_out = open_in | (sense_hi_in & blank_done_out);
   always @(posedge clk_in)
      on_q <= gate_in ? on_q + {1'h0, on_q != 2'h3} : 2'h0;
endmodule // power_stage_model

// File: fault_supervisor_tb.sv
// self-checking bench for the fault supervisor
// assumes shortened timers and the power stage model
`timescale 1ns/100ps
module fault_supervisor_tb;
   reg clk_in = 1'h0, rst_in = 1'h1, gate_request_in = 1'h0;
   reg supply_on_in = 1'h0, supply_off_in = 1'h0, over_power_in = 1'h0;
   reg peak_power_limit_in = 1'h0, voltage_sense_low_in = 1'h0;
   reg ref_good_in = 1'h1, over_temp_in = 1'h0, select_in = 1'h0;
   reg demag_res_high_in = 1'h0, timing_res_fault_in = 1'h0;
   reg bias_below_14v_in = 1'h0, bias_over_in = 1'h0;
   reg cap_discharge_ov_in = 1'h0;
   reg sense_hi = 1'h0, sense_open = 1'h0;
   wire over_current_in, blanking_done_in, demag_active_in;
   wire low_side_gate_drive_out, bias_enable_out, force_restart_out;
   wire recovery_active_out, over_current_fault_out;
   integer miscompares = 0, compares = 0, cycles = 0, seed = 32'hE589;
   integer k, n;
   always #12.5 clk_in = ~clk_in;
   fault_supervisor #(.OPP_CYC(26'h32), .RECOVERY_CYC(26'h64))
      fault_supervisor_i (.clk_in, .rst_in, .gate_request_in,
      .supply_on_in, .supply_off_in, .over_power_in, .peak_power_limit_in,
      .voltage_sense_low_in, .over_current_in, .blanking_done_in,
      .demag_active_in, .ref_good_in, .over_temp_in, .select_in,
      .demag_res_high_in, .bias_below_14v_in, .bias_over_in,
      .timing_res_fault_in, .cap_discharge_ov_in,
      .low_side_gate_drive_out, .bias_enable_out, .force_restart_out,
      .recovery_active_out, .over_current_fault_out);
   power_stage_model power_stage_model_i (.clk_in,
      .gate_in(low_side_gate_drive_out), .sense_hi_in(sense_hi),
      .blank_done_out(blanking_done_in), .demag_out(demag_active_in),
      .open_in(sense_open), .sense_trip_out(over_current_in));
   task stop_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cycles = cycles + 1;
      if (cycles == 50000) begin
         miscompares = miscompares + 1;
         stop_test;
      end
   end
   task cyc(input integer c);
      repeat (c) @(posedge clk_in);
      #2;
   endtask
   task cmp(input string nm, input logic exp, input logic got);
      compares = compares + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task cmp_n(input string nm, input integer exp, input integer got);
      compares = compares + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
      end
   endtask
   function integer limit(input s, input r);
      limit = (s || r) ? 80 : 40;
   endfunction
   // reset, then hold supply on through the 400-cycle check
   task boot;
      rst_in = 1'h1;
      cyc(6);
      rst_in = 1'h0;
      supply_on_in = 1'h1;
      cyc(403);
      supply_on_in = 1'h0;
   endtask
   task pulse(input integer len);
      gate_request_in = 1'h1;
      cyc(len);
      gate_request_in = 1'h0;
      cyc(6);
   endtask
   initial begin
      boot;
      sense_hi = 1'h1;
      for (k = 0; k < 3; k = k + 1) begin
         cmp("oc early", 1'h0, over_current_fault_out);
         pulse(5 + ($random(seed) & 7));
      end
      cmp("oc fault", 1'h1, over_current_fault_out);
      cmp("bias", 1'h0, bias_enable_out);
      sense_hi = 1'h0;
      pulse(10);
      supply_off_in = 1'h1;
      cyc(1);
      supply_off_in = 1'h0;
      cmp("recovery", 1'h1, recovery_active_out);
      cyc(100);
      cmp("recovery done", 1'h0, recovery_active_out);
      supply_off_in = 1'h1;
      cyc(2);
      supply_off_in = 1'h0;
      cmp("oc cleared", 1'h0, over_current_fault_out);
      for (k = 0; k < 2; k = k + 1) begin
         boot;
         pulse(10);
         pulse(100);
         cmp("late pulse", 1'h0, recovery_active_out);
         over_power_in = k[0];
         voltage_sense_low_in = !k[0];
         supply_off_in = 1'h1;
         cyc(2);
         cmp("short recover", 1'h1, recovery_active_out);
         supply_off_in = 1'h0;
      end
      over_power_in = 1'h0;
      voltage_sense_low_in = 1'h0;
      for (k = 0; k < 3; k = k + 1) begin
         select_in = k == 0;
         demag_res_high_in = k == 1;
         boot;
         gate_request_in = 1'h1;
         n = 0;
         repeat (120) begin
            cyc(1);
            if (low_side_gate_drive_out === 1'h1)
               n = n + 1;
         end
         gate_request_in = 1'h0;
         cmp_n("first width", limit(select_in, k == 1), n);
         cmp("first fault", 1'h1, recovery_active_out);
      end
      for (k = 0; k < 4; k = k + 1) begin
         timing_res_fault_in = k == 2;
         bias_below_14v_in = k == 3;
         boot;
         gate_request_in = 1'h1;
         ref_good_in = k != 0;
         over_temp_in = k == 1;
         cyc(4);
         cmp("restart", 1'h1, force_restart_out);
         gate_request_in = 1'h0;
         ref_good_in = 1'h1;
         over_temp_in = 1'h0;
      end
      timing_res_fault_in = 1'h0;
      bias_below_14v_in = 1'h0;
      boot;
      peak_power_limit_in = 1'h1;
      cyc(45);
      cmp("opp early", 1'h0, recovery_active_out);
      cyc(15);
      cmp("opp timeout", 1'h1, recovery_active_out);
      peak_power_limit_in = 1'h0;
      // pulses shorter than blanking keep the over-current path quiet
      for (k = 0; k < 2; k = k + 1) begin
         boot;
         bias_over_in = k == 0;
         sense_open = k == 1;
         for (n = 0; n < 3; n = n + 1) begin
            cmp("streak early", 1'h0, force_restart_out);
            cmp("open early", 1'h0, recovery_active_out);
            pulse(2);
         end
         cmp("bias over", k == 0, force_restart_out);
         cmp("sense open", k == 1, recovery_active_out);
         cmp("open not oc", 1'h0, over_current_fault_out);
         bias_over_in = 1'h0;
         sense_open = 1'h0;
      end
      ref_good_in = 1'h0;
      boot;
      gate_request_in = 1'h1;
      cyc(4);
      cmp("ref held gate", 1'h0, low_side_gate_drive_out);
      cmp("ref held bias", 1'h0, bias_enable_out);
      gate_request_in = 1'h0;
      ref_good_in = 1'h1;
      // 750 us at 40 MHz is 30000 cycles
      boot;
      cap_discharge_ov_in = 1'h1;
      cyc(29990);
      cmp("cap early", 1'h0, force_restart_out);
      cyc(20);
      cmp("cap restart", 1'h1, force_restart_out);
      cap_discharge_ov_in = 1'h0;
      stop_test;
   end
endmodule // fault_supervisor_tb
